// *** include/hpm_cfg.svh ***
// constants for the harvester mode and power mux control block
`ifndef HPM_CFG_SVH
`define HPM_CFG_SVH

// ==========================================================
// clock and times
`define HPM_CLK_MHZ        100
`define HPM_DEAD_NS        5000
`define HPM_DEAD_CYC       ((`HPM_DEAD_NS * `HPM_CLK_MHZ) / 1000)
`define HPM_SAMPLE_MS      64
// milliseconds to cycles kept inside 32-bit int arithmetic
`define HPM_SAMPLE_CYC     (`HPM_SAMPLE_MS * 1000 * `HPM_CLK_MHZ)
`define HPM_SETTLE_MS      32
`define HPM_SETTLE_CYC     (`HPM_SETTLE_MS * 1000 * `HPM_CLK_MHZ)
`define HPM_PULSE_CYC      16
`define HPM_CNT_W          32

`endif

// *** include/hpm_pkg.sv ***
// types for the harvester mode and power mux control block
package hpm_pkg;

	// ==========================================================
	// operating modes
	typedef enum logic [1:0] {
		HPM_SHIP       = 2'h0,
		HPM_COLDSTART  = 2'h1,
		HPM_CHARGE     = 2'h3,
		HPM_THERMAL    = 2'h2
	} hpm_mode_type;

	// ==========================================================
	// comparator levels seen by the controller
	typedef struct packed {
		logic storage_above_chgen;
		logic input_above_coldstart;
		logic power_above_coldstart;
		logic above_uv_rise;
		logic below_uv;
		logic at_ov;
		logic below_ov_hyst;
		logic over_temp;
		logic below_temp_hyst;
	} hpm_sense_type;

	// ==========================================================
	// gate pair
	typedef struct packed {
		logic primary_gate_drive;
		logic secondary_gate_drive;
	} hpm_gates_type;

endpackage

// *** core/hpm_gate_mux.sv ***
// break-before-make driver pair for the store multiplexer
`timescale 1ns/10ps
`default_nettype none
`include "hpm_cfg.svh"

module hpm_gate_mux #(
	parameter int DEAD_CYC = `HPM_DEAD_CYC
) (
	// clock and reset
	input  wire logic                  clock_i,
	input  wire logic                  srst_i,
	// control
	input  wire logic                  good_valid_i,
	input  wire logic                  battery_good_i,
	// gates
	output hpm_pkg::hpm_gates_type     gates_o
);
	import hpm_pkg::*;

	typedef enum logic [1:0] {
		GM_NONE = 2'h0,
		GM_DEAD = 2'h1,
		GM_SEC  = 2'h3,
		GM_PRI  = 2'h2
	} hpm_gm_state_type;

	hpm_gm_state_type state;
	hpm_gm_state_type next_state;
	logic [15:0]      count;
	logic [15:0]      next_count;
	logic             target;
	logic             next_target;
	hpm_gates_type    next_gates;

	// state next values; any store change passes through both-high dead time
	always_comb begin
		next_state  = state;
		next_count  = count;
		next_target = target;
		unique case (state)
			GM_NONE: begin
				if (good_valid_i) begin
					next_state  = GM_DEAD;
					next_target = battery_good_i;
					next_count  = 16'(DEAD_CYC);
				end
			end
			GM_DEAD: begin
				if (count > 16'h0001) begin
					next_count = count - 16'h0001;
				end else begin
					next_state = target ? GM_SEC : GM_PRI;
				end
			end
			GM_SEC: begin
				if (!battery_good_i) begin
					next_state  = GM_DEAD;
					next_target = 1'b0;
					next_count  = 16'(DEAD_CYC);
				end
			end
			GM_PRI: begin
				if (battery_good_i) begin
					next_state  = GM_DEAD;
					next_target = 1'b1;
					next_count  = 16'(DEAD_CYC);
				end
			end
		endcase
		// high means switch open; only the settled state pulls one low
		next_gates.primary_gate_drive   = (next_state != GM_PRI);
		next_gates.secondary_gate_drive = (next_state != GM_SEC);
	end

	// registers; both gates high at reset so no store is connected
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			state   <= GM_NONE;
			count   <= 16'h0000;
			target  <= 1'b0;
			gates_o <= 2'h3;
		end else begin
			state   <= next_state;
			count   <= next_count;
			target  <= next_target;
			gates_o <= next_gates;
		end
	end

endmodule
`default_nettype wire

// *** core/hpm_ctrl.sv ***
// mode sequencer, feedback sampling and store switch control
`timescale 1ns/10ps
`default_nettype none
`include "hpm_cfg.svh"

module hpm_ctrl #(
	parameter int SAMPLE_CYC = `HPM_SAMPLE_CYC,
	parameter int SETTLE_CYC = `HPM_SETTLE_CYC,
	parameter int PULSE_CYC  = `HPM_PULSE_CYC,
	parameter int DEAD_CYC   = `HPM_DEAD_CYC
) (
	// clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   srst_i,
	// analogue comparator levels and pins
	input  wire hpm_pkg::hpm_sense_type sense_i,
	input  wire logic                   enable_i,
	input  wire logic                   good_compare_i,
	// charger and divider controls
	output logic                        coldstart_on_o,
	output logic                        charger_on_o,
	output logic                        divider_bias_node_o,
	output logic                        divider_levels_o,
	output logic                        init_pulse_o,
	output logic                        reference_hold_o,
	output logic                        store_switch_o,
	output logic                        battery_good_o,
	output hpm_pkg::hpm_mode_type       mode_o,
	// store multiplexer gates
	output logic                        primary_gate_drive_o,
	output logic                        secondary_gate_drive_o
);
	import hpm_pkg::*;

	// ==========================================================
	// input synchronisers
	hpm_sense_type sense_meta;
	hpm_sense_type sense;
	logic [1:0]    pin_meta;
	logic [1:0]    pin_sync;

	// two flops before any logic looks at a pin
	// comparator levels move slowly, so two cycles of latency are harmless
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			sense_meta <= '0;
			sense      <= '0;
			pin_meta   <= 2'h0;
			pin_sync   <= 2'h0;
		end else begin
			sense_meta <= sense_i;
			sense      <= sense_meta;
			pin_meta   <= {enable_i, good_compare_i};
			pin_sync   <= pin_meta;
		end
	end

	wire logic enable_s  = pin_sync[1];
	wire logic good_cmp  = pin_sync[0];

	// ==========================================================
	// start-up sequence after coldstart
	typedef enum logic [1:0] {
		SQ_IDLE   = 2'h0,
		SQ_PULSE  = 2'h1,
		SQ_SETTLE = 2'h3,
		SQ_RUN    = 2'h2
	} hpm_seq_type;

	function automatic logic [`HPM_CNT_W-1:0] cyc(input int n);
		cyc = `HPM_CNT_W'(n);
	endfunction

	hpm_mode_type          mode;
	hpm_mode_type          next_mode;
	hpm_seq_type           seq;
	hpm_seq_type           next_seq;
	logic [`HPM_CNT_W-1:0] seq_count;
	logic [`HPM_CNT_W-1:0] next_seq_count;
	logic [`HPM_CNT_W-1:0] tick;
	logic [`HPM_CNT_W-1:0] next_tick;
	logic                  ov_block;
	logic                  next_ov_block;
	logic                  temp_block;
	logic                  next_temp_block;
	logic                  store_sw;
	logic                  next_store_sw;
	logic                  good;
	logic                  next_good;
	logic                  good_valid;
	logic                  next_good_valid;

	// sample strobe: last cycle of each sampling period
	// declared ahead of the processes that read it; divider comparators
	// are only trusted on this strobe, so good, overvoltage and
	// undervoltage-rise decisions change at most once per period
	wire logic sample_now = (seq == SQ_SETTLE || seq == SQ_RUN) && tick == cyc(1);

	// mode selection, highest priority first
	// coldstart outranks the enable pin, which has no effect until the rail is up
	// thermal only stops the charger; the sequence keeps sampling through it
	always_comb begin
		if (!sense.storage_above_chgen) begin
			next_mode = HPM_COLDSTART;
		end else if (enable_s) begin
			next_mode = HPM_SHIP;
		end else if (temp_block) begin
			next_mode = HPM_THERMAL;
		end else begin
			next_mode = HPM_CHARGE;
		end
	end

	// sequencer and sampling timebase
	// pulse and settle lengths run on seq_count, the sampling period on tick
	always_comb begin
		next_seq        = seq;
		next_seq_count  = seq_count;
		next_tick       = tick;
		next_ov_block   = ov_block;
		next_temp_block = temp_block;
		next_store_sw   = store_sw;
		next_good       = good;
		next_good_valid = good_valid;
		// coldstart and ship reset the sequencer, tick and overvoltage block; ship also opens the store switch
		if (mode == HPM_COLDSTART || mode == HPM_SHIP) begin
			next_seq       = SQ_IDLE;
			next_seq_count = '0;
			next_tick      = '0;
			next_ov_block  = 1'b0;
			if (mode == HPM_SHIP) begin
				next_store_sw = 1'b0;
			end
		end else begin
			unique case (seq)
				SQ_IDLE: begin
					next_seq       = SQ_PULSE;
					next_seq_count = cyc(PULSE_CYC);
				end
				SQ_PULSE: begin
					if (seq_count > cyc(1)) begin
						next_seq_count = seq_count - cyc(1);
					end else begin
						next_seq       = SQ_SETTLE;
						next_seq_count = cyc(SETTLE_CYC);
						next_tick      = cyc(SAMPLE_CYC - PULSE_CYC);
					end
				end
				SQ_SETTLE: begin
					if (seq_count > cyc(1)) begin
						next_seq_count = seq_count - cyc(1);
					end else begin
						next_seq = SQ_RUN;
					end
				end
				SQ_RUN: begin
					next_seq = SQ_RUN;
				end
			endcase
			// sampling counter runs from the end of the pulse, preloaded to cover the pulse length
			if (seq == SQ_SETTLE || seq == SQ_RUN) begin
				if (tick > cyc(1)) begin
					next_tick = tick - cyc(1);
				end else begin
					next_tick = cyc(SAMPLE_CYC);
				end
			end
			// divider comparators evaluated only on the sample strobe
			if (sample_now) begin
				next_good_valid = 1'b1;
				next_good       = good_cmp;
				if (sense.at_ov) begin
					next_ov_block = 1'b1;
				end else if (sense.below_ov_hyst) begin
					next_ov_block = 1'b0;
				end
				if (sense.above_uv_rise) begin
					next_store_sw = 1'b1;
				end
			end
		end
		// undervoltage opening protects the store in any mode
		// applied last so it wins over a rise seen on the same strobe
		if (sense.below_uv) begin
			next_store_sw = 1'b0;
		end
		// thermal hysteresis is tracked continuously
		if (sense.over_temp) begin
			next_temp_block = 1'b1;
		end else if (sense.below_temp_hyst) begin
			next_temp_block = 1'b0;
		end
	end

	// state registers; every next value is taken on the same edge
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			mode       <= HPM_COLDSTART;
			seq        <= SQ_IDLE;
			seq_count  <= '0;
			tick       <= '0;
			ov_block   <= 1'b0;
			temp_block <= 1'b0;
			store_sw   <= 1'b0;
			good       <= 1'b0;
			good_valid <= 1'b0;
		end else begin
			mode       <= next_mode;
			seq        <= next_seq;
			seq_count  <= next_seq_count;
			tick       <= next_tick;
			ov_block   <= next_ov_block;
			temp_block <= next_temp_block;
			store_sw   <= next_store_sw;
			good       <= next_good;
			good_valid <= next_good_valid;
		end
	end

	// ==========================================================
	// registered outputs
	logic next_charger;
	logic next_bias;
	logic next_levels;
	logic next_pulse;
	logic next_hold;

	// divider bias: rail connect then level generation, two cycles per sample
	// bias also stands through the init pulse, which resets the divider levels
	always_comb begin
		next_charger = (mode == HPM_CHARGE) && seq == SQ_RUN && !ov_block;
		next_pulse   = (seq == SQ_PULSE);
		next_hold    = (seq == SQ_RUN);
		next_bias    = next_pulse || sample_now;
		next_levels  = (seq == SQ_SETTLE || seq == SQ_RUN) && tick == cyc(SAMPLE_CYC);
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			coldstart_on_o      <= 1'b0;
			charger_on_o        <= 1'b0;
			divider_bias_node_o <= 1'b0;
			divider_levels_o    <= 1'b0;
			init_pulse_o        <= 1'b0;
			reference_hold_o    <= 1'b0;
			store_switch_o      <= 1'b0;
			battery_good_o      <= 1'b0;
			mode_o              <= HPM_COLDSTART;
		end else begin
			coldstart_on_o      <= (next_mode == HPM_COLDSTART)
				&& sense.input_above_coldstart && sense.power_above_coldstart;
			charger_on_o        <= next_charger;
			divider_bias_node_o <= next_bias;
			divider_levels_o    <= next_levels;
			init_pulse_o        <= next_pulse;
			reference_hold_o    <= next_hold;
			store_switch_o      <= store_sw && mode != HPM_SHIP;
			battery_good_o      <= good;
			mode_o              <= mode;
		end
	end

	// ==========================================================
	// store multiplexer
	// the mux holds both gates open until the first good sample is valid
	hpm_gates_type gates;

	hpm_gate_mux #(
		.DEAD_CYC (DEAD_CYC)
	) u_gate_mux (
		.clock_i        (clock_i),
		.srst_i         (srst_i),
		.good_valid_i   (good_valid),
		.battery_good_i (good),
		.gates_o        (gates)
	);

	// gate pair comes straight from the mux flops
	assign primary_gate_drive_o   = gates.primary_gate_drive;
	assign secondary_gate_drive_o = gates.secondary_gate_drive;

endmodule
`default_nettype wire

// *** dv/hpm_ctrl_asserts.sv ***
// port checker for the mode and store mux controller
`timescale 1ns/10ps
`default_nettype none
module hpm_ctrl_asserts #(
	parameter int SAMPLE_CYC = 200,
	parameter int PULSE_CYC  = 4,
	parameter int DEAD_CYC   = 5
) (
	// clock and reset
	input wire logic                   clock_i,
	input wire logic                   srst_i,
	// sensed levels
	input wire hpm_pkg::hpm_sense_type sense_i,
	// watched outputs
	input wire logic                   coldstart_on_o,
	input wire logic                   charger_on_o,
	input wire logic                   divider_bias_node_o,
	input wire logic                   divider_levels_o,
	input wire logic                   init_pulse_o,
	input wire logic                   store_switch_o,
	input wire logic                   battery_good_o,
	input wire hpm_pkg::hpm_mode_type  mode_o,
	input wire logic                   primary_gate_drive_o,
	input wire logic                   secondary_gate_drive_o
);
	import hpm_pkg::*;
	// ==========================================================
	// helper counters
	// window is four cycles loose either side, though the first sample lands exactly SAMPLE_CYC after the pulse rises
	localparam int LO = SAMPLE_CYC - 4;
	localparam int HI = SAMPLE_CYC + 4;
	int   both_cnt;
	int   plen;
	logic seen;
	// dead time and init pulse length counters
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			both_cnt <= 0;
			plen     <= 0;
			seen     <= 1'b0;
		end else begin
			both_cnt <= (primary_gate_drive_o && secondary_gate_drive_o) ? both_cnt + 1 : 0;
			plen     <= init_pulse_o ? plen + 1 : 0;
			seen     <= seen | divider_levels_o;
		end
	end
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (srst_i);
	// ==========================================================
	// sequences
	sequence s_init_end;
		$fell(init_pulse_o);
	endsequence
	sequence s_charger_quiet;
		!charger_on_o [*8];
	endsequence
	// ==========================================================
	// assertions
	AST_NO_OVERLAP: assert property (primary_gate_drive_o || secondary_gate_drive_o)
		else $error("both store switches closed");
	AST_DEAD_TIME: assert property (($fell(primary_gate_drive_o) || $fell(secondary_gate_drive_o))
		|-> both_cnt >= DEAD_CYC) else $error("dead time too short");
	AST_GOOD_RISE: assert property ($fell(secondary_gate_drive_o) |-> primary_gate_drive_o
		&& battery_good_o) else $error("secondary connect out of order");
	AST_GOOD_FALL: assert property ($fell(primary_gate_drive_o) |-> secondary_gate_drive_o
		&& !battery_good_o) else $error("primary connect out of order");
	AST_HOLD_OPEN: assert property (!seen |-> primary_gate_drive_o && secondary_gate_drive_o)
		else $error("store connected before first evaluation");
	AST_LEVELS_AFTER_BIAS: assert property ($rose(divider_levels_o) |-> $past(divider_bias_node_o)
		##1 !divider_levels_o) else $error("divider levels without bias");
	AST_PULSE_LEN: assert property (s_init_end |-> plen == PULSE_CYC)
		else $error("init pulse length wrong");
	AST_SETTLE: assert property (s_init_end |-> s_charger_quiet)
		else $error("charger on during settle");
	AST_FIRST_SAMPLE: assert property ($rose(init_pulse_o) |-> ##[LO:HI] divider_levels_o)
		else $error("first sample late");
	AST_COLD: assert property (mode_o == HPM_COLDSTART |-> !charger_on_o && !divider_levels_o)
		else $error("feature active in coldstart");
	AST_SHIP: assert property (mode_o == HPM_SHIP |-> !charger_on_o && !store_switch_o)
		else $error("ship mode not shut down");
	AST_THERMAL: assert property (mode_o == HPM_THERMAL |-> !charger_on_o)
		else $error("charger on in thermal shutdown");
	AST_UV_OPEN: assert property (sense_i.below_uv [*5] |-> !store_switch_o)
		else $error("store switch closed below uv");
endmodule
bind hpm_ctrl hpm_ctrl_asserts #(.SAMPLE_CYC(SAMPLE_CYC), .PULSE_CYC(PULSE_CYC),
	.DEAD_CYC(DEAD_CYC)) u_chk (.clock_i, .srst_i, .sense_i, .coldstart_on_o, .charger_on_o,
	.divider_bias_node_o, .divider_levels_o, .init_pulse_o, .store_switch_o, .battery_good_o,
	.mode_o, .primary_gate_drive_o, .secondary_gate_drive_o);
`default_nettype wire

// *** dv/hpm_store_pair_model.sv ***
// external back-to-back switch pair feeding the system rail
`timescale 1ns/10ps
`default_nettype none
module hpm_store_pair_model (
	// gates, high = switch open
	input  wire logic primary_gate_drive_i,
	input  wire logic secondary_gate_drive_i,
	// rail source: 0 none, 1 primary, 2 secondary, 3 shorted stores
	output logic [1:0] rail_src_o
);
	// both low would short the stores through the rail
	assign rail_src_o = {!secondary_gate_drive_i, !primary_gate_drive_i};
endmodule
`default_nettype wire

// *** dv/tb_top.sv ***
// self-checking bench for the mode and store mux controller
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR %s exp %0h got %0h", n, e, g); end end
module tb_top;
	import hpm_pkg::*;
	logic          clock_i = 1'b0;
	logic          srst_i = 1'b1;
	hpm_sense_type sense_i = '0;
	logic          enable_i = 1'b0;
	logic          good_i = 1'b0;
	logic          cs_on, chg_on, bias, lvl, init, ref_h, sw, good, pri, sec;
	hpm_mode_type  mode;
	logic [1:0]    rail;
	int            error_cnt = 0;
	int            tests_run = 0;
	int            n;
	// small counts keep the run short
	hpm_ctrl #(.SAMPLE_CYC(200), .SETTLE_CYC(100), .PULSE_CYC(4), .DEAD_CYC(5)) u_dut (
		.clock_i(clock_i), .srst_i(srst_i), .sense_i(sense_i), .enable_i(enable_i),
		.good_compare_i(good_i), .coldstart_on_o(cs_on), .charger_on_o(chg_on),
		.divider_bias_node_o(bias), .divider_levels_o(lvl), .init_pulse_o(init),
		.reference_hold_o(ref_h), .store_switch_o(sw), .battery_good_o(good), .mode_o(mode),
		.primary_gate_drive_o(pri), .secondary_gate_drive_o(sec));
	hpm_store_pair_model u_pair (.primary_gate_drive_i(pri), .secondary_gate_drive_i(sec),
		.rail_src_o(rail));
	initial begin
		forever #5 clock_i = ~clock_i;
	end
	task automatic cyc(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_cold;
		cyc(6);
		`CHK("gates", 2'h3, {pri, sec})
		sense_i.input_above_coldstart = 1'b1;
		sense_i.power_above_coldstart = 1'b1;
		enable_i = 1'b1;
		cyc(6);
		`CHK("mode", HPM_COLDSTART, mode)
		`CHK("cs_on", 1'b1, cs_on)
		`CHK("chg", 1'b0, chg_on)
		enable_i = 1'b0;
		$display("t_cold done");
	endtask
	task automatic t_start;
		good_i = 1'b1;
		sense_i.above_uv_rise = 1'b1;
		sense_i.storage_above_chgen = 1'b1;
		for (n = 0; n < 20 && !init; n++) cyc(1);
		`CHK("init", 1'b1, init)
		`CHK("bias", 1'b1, bias)
		`CHK("chg", 1'b0, chg_on)
		`CHK("ref", 1'b0, ref_h)
		for (n = 0; n < 300 && !lvl; n++) cyc(1);
		`CHK("first", 1'b1, n > 190 && n < 210)
		`CHK("bias", 1'b0, bias)
		cyc(20);
		`CHK("good", 1'b1, good)
		`CHK("rail", 2'h2, rail)
		`CHK("chg", 1'b1, chg_on)
		`CHK("ref", 1'b1, ref_h)
		`CHK("sw", 1'b1, sw)
		$display("t_start done");
	endtask
	task automatic t_good_fall;
		good_i = 1'b0;
		sense_i.at_ov = 1'b1;
		cyc(230);
		`CHK("rail", 2'h1, rail)
		`CHK("sec", 1'b1, sec)
		`CHK("chg", 1'b0, chg_on)
		sense_i.at_ov = 1'b0;
		sense_i.below_ov_hyst = 1'b1;
		cyc(200);
		`CHK("chg", 1'b1, chg_on)
		$display("t_good_fall done");
	endtask
	task automatic t_thermal;
		sense_i.over_temp = 1'b1;
		cyc(6);
		`CHK("mode", HPM_THERMAL, mode)
		`CHK("chg", 1'b0, chg_on)
		sense_i.over_temp = 1'b0;
		sense_i.below_temp_hyst = 1'b1;
		cyc(6);
		`CHK("mode", HPM_CHARGE, mode)
		`CHK("chg", 1'b1, chg_on)
		$display("t_thermal done");
	endtask
	task automatic t_uv_ship;
		sense_i.below_uv = 1'b1;
		cyc(6);
		`CHK("sw", 1'b0, sw)
		enable_i = 1'b1;
		cyc(6);
		`CHK("mode", HPM_SHIP, mode)
		`CHK("chg", 1'b0, chg_on)
		$display("t_uv_ship done");
	endtask
	initial begin
		cyc(2);
		srst_i = 1'b0;
		t_cold();
		t_start();
		t_good_fall();
		t_thermal();
		t_uv_ship();
		end_sim();
	end
	// watchdog well beyond the expected run of under a thousand cycles
	initial begin
		#200000;
		error_cnt++;
		end_sim();
	end
endmodule
`default_nettype wire
